// *** rk_defs.vh ***
// Register offsets, reset values and timing counts of the rotary knob register file.
`ifndef RK_DEFS_VH
`define RK_DEFS_VH
`define RK_OFS_STATUS 8'h01
`define RK_OFS_IRQ_GATE 8'h04
`define RK_OFS_MOTION_AGE 8'h09
`define RK_OFS_BUTTON_AGE 8'h0B
`define RK_OFS_RED_LEVEL 8'h0D
`define RK_OFS_GREEN_LEVEL 8'h0E
`define RK_OFS_BLUE_LEVEL 8'h0F
`define RK_OFS_RED_STEP 8'h10
`define RK_OFS_GREEN_STEP 8'h12
`define RK_OFS_BLUE_STEP 8'h14
`define RK_OFS_IRQ_DELAY 8'h16
`define RK_OFS_SLAVE_ADDR 8'h18
`define RK_RST_LEVEL 8'hFF
`define RK_RST_IRQ_GATE 2'h3
`define RK_RST_IRQ_DELAY 16'h0100
`define RK_RST_SLAVE_ADDR 7'h3F
`define RK_JUMPER_ADDR 7'h3E
`define RK_ADDR_MIN 7'h08
`define RK_ADDR_MAX 7'h77
`define RK_ST_HELD 3
`define RK_ST_CLICKED 2
`define RK_ST_SW_IRQ 1
`define RK_ST_ROT_IRQ 0
`define RK_MS_NS 1000000
`define RK_CLK_NS 100
`define RK_MS_CYCLES (`RK_MS_NS / `RK_CLK_NS)
`endif

// *** rk_i2c_master_model.sv ***
// Behavioural bus master that talks to the knob over its two-wire bus.
`timescale 1ns/10ps
module rk_i2c_master_model (
    // Bus clock, driven high and low directly, and data pull, released high by the pull-up.
    output logic o_scl,
    output logic o_sda_low,
    input wire i_sda
);
    // Both lines start released.
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    // One bit: data moves mid-low, is sampled mid-high, 800 ns per bit.
    task automatic bit_io(input logic b, output logic r);
        #200 o_sda_low = !b;
        #200 o_scl = 1'b1;
        #200 r = i_sda;
        #200 o_scl = 1'b0;
    endtask
    // Start, or repeated start after a byte.
    task automatic start();
        #200 o_sda_low = 1'b0;
        #200 o_scl = 1'b1;
        #200 o_sda_low = 1'b1;
        #200 o_scl = 1'b0;
    endtask
    // Stop, then the bus rests high.
    task automatic stop();
        #200 o_sda_low = 1'b1;
        #200 o_scl = 1'b1;
        #200 o_sda_low = 1'b0;
        #200;
    endtask
    // Byte out, high bit first, then the slave's acknowledge.
    task automatic tx(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = !r;
    endtask
    // Byte in; the last one is refused so the slave lets go.
    task automatic rx(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(last, r);
    endtask
endmodule

// *** rk_register_file.v ***
// Rotary knob register file with its I2C slave, timers and brightness stepping.
`timescale 1ns/10ps
// Function
// - Sixteen-bit millisecond age since last movement.
// - Sixteen-bit millisecond age since button event.
// - Three brightness bytes defaulting to 255.
// - Signed per-colour tick steps, default zero.
// - Movement interrupt waits programmable delay.
// - Slave address from address register, 0x08-0x77.
// - Closed jumper forces address 0x3E.
// - Index write first, then read or write.
// - Pointer advances after every data byte.
// - Each up tick adds, each down tick subtracts, signed step per colour.
// - Steps restored from non-volatile store at power-up.
// - Status bits held, clicked, switch and rotation.
// - Interrupt gate bits enable sources, default on.
`include "rk_defs.vh"
module rk_register_file #(
    parameter MS_CYCLES = `RK_MS_CYCLES
) (
    // Clock and reset.
    input wire i_clk,
    input wire i_rst,
    // I2C pins, open drain data.
    input wire i_scl,
    input wire i_sda,
    output wire o_sda,
    output wire o_sda_oe,
    // Knob inputs from the board, asynchronous.
    input wire i_enc_tick,
    input wire i_enc_up,
    input wire i_switch_n,
    input wire i_addr_jumper,
    // Non-volatile step values, stable at power-up.
    input wire [47:0] i_nvm_steps,
    // LED levels and interrupt request.
    output reg [7:0] o_red_level,
    output reg [7:0] o_green_level,
    output reg [7:0] o_blue_level,
    output wire o_irq_n_oe
);
    // Synchroniser stages for the six asynchronous inputs.
    reg [5:0] sync1_q;
    reg [5:0] sync2_q;
    reg [5:0] prev_q;
    // Button and timer state.
    reg held_q, clicked_q, sw_irq_q, rot_irq_q, rot_pend_q;
    reg [1:0] irq_gate_q;
    reg [15:0] motion_age_q, button_age_q, irq_delay_q, pend_ms_q;
    reg [15:0] red_step_q, green_step_q, blue_step_q;
    reg [6:0] slave_addr_q;
    reg [31:0] ms_cnt_q;
    reg nvm_loaded_q;
    // I2C slave state.
    reg [2:0] st_q;
    reg [3:0] bit_q;
    reg [7:0] shift_q, ptr_q, tx_q;
    reg rw_q, first_q, sda_out_q;
    localparam ST_IDLE = 3'd0;
    localparam ST_ADDR = 3'd1;
    localparam ST_AACK = 3'd2;
    localparam ST_WR = 3'd3;
    localparam ST_WACK = 3'd4;
    localparam ST_RD = 3'd5;
    localparam ST_RACK = 3'd6;

    // Saturating add (up) or subtract (down) of a signed step to a level.
    function [7:0] sat_add;
        input [7:0] lvl;
        input [15:0] step;
        input up;
        reg signed [17:0] s;
        begin
            s = $signed({10'h000, lvl}) + (up ? $signed({{2{step[15]}}, step}) : -$signed({{2{step[15]}}, step}));
            if (s < 0) begin
                sat_add = 8'h00;
            end else if (s > 255) begin
                sat_add = 8'hFF;
            end else begin
                sat_add = s[7:0];
            end
        end
    endfunction

    // Register read mux; high byte sits at the lower offset.
    function [7:0] rd_byte;
        input [7:0] a;
        begin
            case (a)
                `RK_OFS_STATUS: rd_byte = {4'h0, held_q, clicked_q, sw_irq_q, rot_irq_q};
                `RK_OFS_IRQ_GATE: rd_byte = {6'h00, irq_gate_q};
                8'h09: rd_byte = motion_age_q[15:8];
                8'h0A: rd_byte = motion_age_q[7:0];
                8'h0B: rd_byte = button_age_q[15:8];
                8'h0C: rd_byte = button_age_q[7:0];
                8'h0D: rd_byte = o_red_level;
                8'h0E: rd_byte = o_green_level;
                8'h0F: rd_byte = o_blue_level;
                8'h10: rd_byte = red_step_q[15:8];
                8'h11: rd_byte = red_step_q[7:0];
                8'h12: rd_byte = green_step_q[15:8];
                8'h13: rd_byte = green_step_q[7:0];
                8'h14: rd_byte = blue_step_q[15:8];
                8'h15: rd_byte = blue_step_q[7:0];
                8'h16: rd_byte = irq_delay_q[15:8];
                8'h17: rd_byte = irq_delay_q[7:0];
                `RK_OFS_SLAVE_ADDR: rd_byte = {1'b0, slave_addr_q};
                default: rd_byte = 8'h00;
            endcase
        end
    endfunction

    // Synchronised views of the pins.
    wire scl_s = sync2_q[0];
    wire sda_s = sync2_q[1];
    wire tick_s = sync2_q[2];
    wire up_s = sync2_q[3];
    wire sw_s = ~sync2_q[4];
    wire jmp_s = sync2_q[5];
    wire scl_rise = scl_s & ~prev_q[0];
    wire scl_fall = ~scl_s & prev_q[0];
    wire start_c = scl_s & prev_q[0] & prev_q[1] & ~sda_s;
    wire stop_c = scl_s & prev_q[0] & ~prev_q[1] & sda_s;
    wire tick_rise = tick_s & ~prev_q[2];
    wire ms_pulse = (ms_cnt_q == MS_CYCLES - 1);
    wire [6:0] my_addr = jmp_s ? `RK_JUMPER_ADDR : slave_addr_q;
    // A write byte is committed at the eighth rising edge of a data byte.
    wire wr_commit = (st_q == ST_WR) & scl_rise & (bit_q == 4'd7) & ~first_q;
    wire [7:0] wr_data = {shift_q[6:0], sda_s};

    assign o_sda = 1'b0;
    assign o_sda_oe = sda_out_q;
    assign o_irq_n_oe = (sw_irq_q & irq_gate_q[1]) | (rot_irq_q & irq_gate_q[0]);

    // Two-flop synchronisers and edge history.
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sync1_q <= 6'h33;
            sync2_q <= 6'h33;
            prev_q <= 6'h33;
        end else begin
            sync1_q <= {i_addr_jumper, i_switch_n, i_enc_up, i_enc_tick, i_sda, i_scl};
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    // I2C slave: address match, pointer load, auto-increment, read shift.
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_q <= ST_IDLE;
            bit_q <= 4'd0;
            shift_q <= 8'h00;
            ptr_q <= 8'h00;
            tx_q <= 8'h00;
            rw_q <= 1'b0;
            first_q <= 1'b0;
            sda_out_q <= 1'b0;
        end else if (start_c) begin
            st_q <= ST_ADDR;
            bit_q <= 4'd0;
            sda_out_q <= 1'b0;
        end else if (stop_c) begin
            st_q <= ST_IDLE;
            sda_out_q <= 1'b0;
        end else begin
            case (st_q)
                ST_ADDR: begin
                    if (scl_rise) begin
                        shift_q <= wr_data;
                        bit_q <= bit_q + 4'd1;
                    end
                    if (scl_fall && bit_q == 4'd8) begin
                        if (shift_q[7:1] == my_addr) begin
                            rw_q <= shift_q[0];
                            first_q <= ~shift_q[0];
                            tx_q <= rd_byte(ptr_q);
                            sda_out_q <= 1'b1;
                            st_q <= ST_AACK;
                        end else begin
                            st_q <= ST_IDLE;
                        end
                    end
                end
                ST_AACK, ST_WACK: begin
                    if (scl_fall) begin
                        bit_q <= 4'd0;
                        st_q <= rw_q ? ST_RD : ST_WR;
                        sda_out_q <= rw_q & ~tx_q[7];
                    end
                end
                ST_WR: begin
                    if (scl_rise) begin
                        shift_q <= wr_data;
                        bit_q <= bit_q + 4'd1;
                        if (bit_q == 4'd7) begin
                            if (first_q) begin
                                ptr_q <= wr_data;
                            end else begin
                                ptr_q <= ptr_q + 8'h01;
                            end
                            first_q <= 1'b0;
                        end
                    end
                    if (scl_fall && bit_q == 4'd8) begin
                        sda_out_q <= 1'b1;
                        st_q <= ST_WACK;
                    end
                end
                ST_RD: begin
                    if (scl_fall) begin
                        bit_q <= bit_q + 4'd1;
                        tx_q <= {tx_q[6:0], 1'b0};
                        sda_out_q <= (bit_q != 4'd7) & ~tx_q[6];
                        if (bit_q == 4'd7) begin
                            st_q <= ST_RACK;
                            ptr_q <= ptr_q + 8'h01;
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        st_q <= sda_s ? ST_IDLE : ST_RACK;
                        tx_q <= rd_byte(ptr_q);
                    end
                    if (scl_fall) begin
                        bit_q <= 4'd0;
                        st_q <= ST_RD;
                        sda_out_q <= ~tx_q[7];
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // Knob state, timers and registers written over the bus.
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ms_cnt_q <= 32'h0000_0000;
            held_q <= 1'b0;
            clicked_q <= 1'b0;
            sw_irq_q <= 1'b0;
            rot_irq_q <= 1'b0;
            rot_pend_q <= 1'b0;
            pend_ms_q <= 16'h0000;
            irq_gate_q <= `RK_RST_IRQ_GATE;
            motion_age_q <= 16'h0000;
            button_age_q <= 16'h0000;
            irq_delay_q <= `RK_RST_IRQ_DELAY;
            red_step_q <= 16'h0000;
            green_step_q <= 16'h0000;
            blue_step_q <= 16'h0000;
            slave_addr_q <= `RK_RST_SLAVE_ADDR;
            nvm_loaded_q <= 1'b0;
            o_red_level <= `RK_RST_LEVEL;
            o_green_level <= `RK_RST_LEVEL;
            o_blue_level <= `RK_RST_LEVEL;
        end else begin
            // Millisecond prescaler.
            ms_cnt_q <= ms_pulse ? 32'h0000_0000 : ms_cnt_q + 32'h0000_0001;
            // Steps are taken from the store once after reset release.
            nvm_loaded_q <= 1'b1;
            if (!nvm_loaded_q) begin
                red_step_q <= i_nvm_steps[47:32];
                green_step_q <= i_nvm_steps[31:16];
                blue_step_q <= i_nvm_steps[15:0];
            end
            // Age counters hold at the top of their range.
            if (ms_pulse && motion_age_q != 16'hFFFF) begin
                motion_age_q <= motion_age_q + 16'h0001;
            end
            if (ms_pulse && button_age_q != 16'hFFFF) begin
                button_age_q <= button_age_q + 16'h0001;
            end
            held_q <= sw_s;
            // Bus writes; hardware sets below take priority.
            if (wr_commit) begin
                case (ptr_q)
                    `RK_OFS_STATUS: begin
                        clicked_q <= wr_data[`RK_ST_CLICKED];
                        sw_irq_q <= wr_data[`RK_ST_SW_IRQ];
                        rot_irq_q <= wr_data[`RK_ST_ROT_IRQ];
                    end
                    `RK_OFS_IRQ_GATE: irq_gate_q <= wr_data[1:0];
                    8'h09: motion_age_q[15:8] <= wr_data;
                    8'h0A: motion_age_q[7:0] <= wr_data;
                    8'h0B: button_age_q[15:8] <= wr_data;
                    8'h0C: button_age_q[7:0] <= wr_data;
                    8'h0D: o_red_level <= wr_data;
                    8'h0E: o_green_level <= wr_data;
                    8'h0F: o_blue_level <= wr_data;
                    8'h10: red_step_q[15:8] <= wr_data;
                    8'h11: red_step_q[7:0] <= wr_data;
                    8'h12: green_step_q[15:8] <= wr_data;
                    8'h13: green_step_q[7:0] <= wr_data;
                    8'h14: blue_step_q[15:8] <= wr_data;
                    8'h15: blue_step_q[7:0] <= wr_data;
                    8'h16: irq_delay_q[15:8] <= wr_data;
                    8'h17: irq_delay_q[7:0] <= wr_data;
                    `RK_OFS_SLAVE_ADDR: begin
                        // Out-of-range addresses are ignored.
                        if (wr_data[6:0] >= `RK_ADDR_MIN && wr_data[6:0] <= `RK_ADDR_MAX && !wr_data[7]) begin
                            slave_addr_q <= wr_data[6:0];
                        end
                    end
                    default: begin
                    end
                endcase
            end
            // Movement interrupt waits for the delay; placed after the bus write so the set wins.
            if (rot_pend_q && ms_pulse) begin
                pend_ms_q <= pend_ms_q + 16'h0001;
            end
            if (rot_pend_q && pend_ms_q >= irq_delay_q) begin
                rot_pend_q <= 1'b0;
                rot_irq_q <= 1'b1;
            end
            // Button edges restart the age and raise flags.
            if (sw_s != held_q) begin
                button_age_q <= 16'h0000;
                sw_irq_q <= 1'b1;
                if (!sw_s) begin
                    clicked_q <= 1'b1;
                end
            end
            // Encoder tick steps each colour and restarts the timers.
            if (tick_rise) begin
                motion_age_q <= 16'h0000;
                rot_pend_q <= 1'b1;
                pend_ms_q <= 16'h0000;
                o_red_level <= sat_add(o_red_level, red_step_q, up_s);
                o_green_level <= sat_add(o_green_level, green_step_q, up_s);
                o_blue_level <= sat_add(o_blue_level, blue_step_q, up_s);
            end
        end
    end
endmodule

// *** rk_register_file_bench.sv ***
// Self-checking bench for the rotary knob register file.
`timescale 1ns/10ps
`define CHK(got, exp) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) begin \
            miscompares++; \
            $display("CHECK FAILED at %0t: got %h, expected %h", $time, (got), (exp)); \
        end \
    end
module rk_register_file_bench;
    // Design outputs.
    wire o_sda;
    wire o_sda_oe;
    wire [7:0] o_red_level;
    wire [7:0] o_green_level;
    wire [7:0] o_blue_level;
    wire o_irq_n_oe;
    // Stimulus, driven on the rising clock edge.
    logic i_clk = 1'b0;
    logic i_rst;
    logic i_enc_tick;
    logic i_enc_up;
    logic i_switch_n;
    logic i_addr_jumper;
    logic [47:0] i_nvm_steps;
    // Bus wires; data is pulled up unless a party pulls it low.
    wire scl;
    wire m_low;
    wire sda_line = !(m_low || o_sda_oe);
    // Bookkeeping and scratch values.
    int miscompares = 0;
    int checks_done = 0;
    logic [6:0] dev = 7'h3F;
    logic [23:0] v;
    logic [7:0] b;
    logic a;
    rk_register_file #(.MS_CYCLES(10)) i_rk_register_file (
        .i_clk(i_clk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda_line), .o_sda(o_sda), .o_sda_oe(o_sda_oe),
        .i_enc_tick(i_enc_tick), .i_enc_up(i_enc_up), .i_switch_n(i_switch_n), .i_addr_jumper(i_addr_jumper),
        .i_nvm_steps(i_nvm_steps), .o_red_level(o_red_level), .o_green_level(o_green_level),
        .o_blue_level(o_blue_level), .o_irq_n_oe(o_irq_n_oe));
    rk_i2c_master_model i_rk_i2c_master_model (.o_scl(scl), .o_sda_low(m_low), .i_sda(sda_line));
    // Clock at 10 MHz.
    always #50 i_clk = ~i_clk;
    // Leave the clock edge, address the knob for writing and send the index.
    task automatic head(input logic [7:0] idx);
        @(posedge i_clk);
        #13;
        i_rk_i2c_master_model.start();
        i_rk_i2c_master_model.tx({dev, 1'b0}, a);
        `CHK(a, 1'b1)
        i_rk_i2c_master_model.tx(idx, a);
    endtask
    // Write n bytes from one index, high byte first.
    task automatic wr(input logic [7:0] idx, input logic [23:0] d, input int n);
        head(idx);
        for (int k = n - 1; k >= 0; k--) begin
            i_rk_i2c_master_model.tx(d[8 * k +: 8], a);
        end
        i_rk_i2c_master_model.stop();
    endtask
    // Read n bytes into v after a repeated start.
    task automatic rd(input logic [7:0] idx, input int n);
        head(idx);
        i_rk_i2c_master_model.start();
        i_rk_i2c_master_model.tx({dev, 1'b1}, a);
        v = 24'h00_0000;
        for (int k = n - 1; k >= 0; k--) begin
            i_rk_i2c_master_model.rx(k == 0, b);
            v[8 * k +: 8] = b;
        end
        i_rk_i2c_master_model.stop();
    endtask
    // Address-only transfer to see whether an address is answered.
    task automatic probe(input logic [6:0] adr, input logic exp);
        @(posedge i_clk);
        #13;
        i_rk_i2c_master_model.start();
        i_rk_i2c_master_model.tx({adr, 1'b0}, a);
        i_rk_i2c_master_model.stop();
        `CHK(a, exp)
    endtask
    // One encoder tick; direction settles a cycle before the edge.
    task automatic tick(input logic up);
        @(posedge i_clk);
        i_enc_up <= up;
        @(posedge i_clk);
        i_enc_tick <= 1'b1;
        repeat (6) @(posedge i_clk);
        i_enc_tick <= 1'b0;
        repeat (6) @(posedge i_clk);
    endtask
    // Verdict and end of run.
    task automatic report_and_stop();
        if (miscompares == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Watchdog well beyond the expected run of about 0.75 ms.
    initial begin
        #5ms;
        miscompares++;
        report_and_stop();
    end
    // Main sequence.
    initial begin
        i_rst <= 1'b1;
        i_enc_tick <= 1'b0;
        i_enc_up <= 1'b1;
        i_switch_n <= 1'b1;
        i_addr_jumper <= 1'b0;
        i_nvm_steps <= 48'h0014_FFF6_0000;
        repeat (8) @(posedge i_clk);
        i_rst <= 1'b0;
        repeat (6) @(posedge i_clk);
        rd(8'h0D, 3);
        `CHK(v, 24'hFF_FFFF)
        rd(8'h10, 3);
        `CHK(v, 24'h00_14FF)
        rd(8'h12, 2);
        `CHK(v, 24'h00_FFF6)
        rd(8'h16, 2);
        `CHK(v, 24'h00_0100)
        rd(8'h04, 1);
        `CHK(v, 24'h00_0003)
        wr(8'h0D, 24'hF5_0580, 3);
        `CHK({o_red_level, o_green_level, o_blue_level}, 24'hF5_0580)
        tick(1'b1);
        `CHK({o_red_level, o_green_level, o_blue_level}, 24'hFF_0080)
        tick(1'b0);
        `CHK({o_red_level, o_green_level, o_blue_level}, 24'hEB_0A80)
        wr(8'h09, 24'h00_0000, 2);
        rd(8'h09, 2);
        `CHK(v > 24'h00_000A && v < 24'h00_0064, 1'b1)
        @(posedge i_clk);
        i_switch_n <= 1'b0;
        rd(8'h01, 1);
        `CHK(v[3], 1'b1)
        @(posedge i_clk);
        i_switch_n <= 1'b1;
        wr(8'h0B, 24'h00_0000, 2);
        rd(8'h0B, 2);
        `CHK(v > 24'h00_000A && v < 24'h00_0064, 1'b1)
        rd(8'h01, 1);
        `CHK(v[3:2], 2'h1)
        wr(8'h16, 24'h00_0005, 2);
        wr(8'h01, 24'h00_0000, 1);
        tick(1'b1);
        repeat (20) @(posedge i_clk);
        `CHK(o_irq_n_oe, 1'b0)
        repeat (60) @(posedge i_clk);
        `CHK(o_irq_n_oe, 1'b1)
        wr(8'h04, 24'h00_0002, 1);
        `CHK(o_irq_n_oe, 1'b0)
        wr(8'h04, 24'h00_0001, 1);
        `CHK(o_irq_n_oe, 1'b1)
        wr(8'h14, 24'h00_FF01, 2);
        rd(8'h14, 2);
        `CHK(v, 24'h00_FF01)
        wr(8'h18, 24'h00_0077, 1);
        dev = 7'h77;
        probe(7'h3F, 1'b0);
        for (int k = 0; k < 2; k++) begin
            wr(8'h18, k ? 24'h00_0078 : 24'h00_0007, 1);
            probe(7'h77, 1'b1);
        end
        @(posedge i_clk);
        i_addr_jumper <= 1'b1;
        probe(7'h3E, 1'b1);
        probe(7'h77, 1'b0);
        report_and_stop();
    end
endmodule
bind rk_register_file rk_register_file_checker #(.MS_CYCLES(MS_CYCLES)) i_rk_register_file_checker (
    .i_clk(i_clk), .i_rst(i_rst), .i_scl(i_scl), .i_enc_tick(i_enc_tick), .o_sda(o_sda), .o_sda_oe(o_sda_oe),
    .o_red_level(o_red_level), .o_green_level(o_green_level), .o_blue_level(o_blue_level),
    .o_irq_n_oe(o_irq_n_oe));

// *** rk_register_file_properties.sv ***
// Pin-level assertions for the rotary knob register file.
`timescale 1ns/10ps
module rk_register_file_checker #(
    parameter MS_CYCLES = 10000
) (
    // Clock, reset and watched inputs.
    input wire i_clk,
    input wire i_rst,
    input wire i_scl,
    input wire i_enc_tick,
    // Watched outputs.
    input wire o_sda,
    input wire o_sda_oe,
    input wire [7:0] o_red_level,
    input wire [7:0] o_green_level,
    input wire [7:0] o_blue_level,
    input wire o_irq_n_oe
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    // Cycles since the last edge on the tick or bus clock pin, held at 63.
    logic [5:0] quiet_q;
    logic tick_q;
    logic scl_q;
    // Level changes must follow a tick or bus activity closely.
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            quiet_q <= 6'h00;
            tick_q <= 1'b0;
            scl_q <= 1'b1;
        end else begin
            tick_q <= i_enc_tick;
            scl_q <= i_scl;
            if (tick_q != i_enc_tick || scl_q != i_scl) begin
                quiet_q <= 6'h00;
            end else if (quiet_q != 6'h3F) begin
                quiet_q <= quiet_q + 6'h01;
            end
        end
    end
    // Bus clock held high for a while, so no transfer is under way.
    sequence s_bus_idle;
        i_scl [*8];
    endsequence
    // Bus clock low now and on the two edges before.
    sequence s_scl_low3;
        !i_scl && !$past(i_scl, 1) && !$past(i_scl, 2);
    endsequence
    a_sda_low_only: assert property (o_sda == 1'b0)
        else $error("Data pin driven high.");
    a_ack_rise_low: assert property ($rose(o_sda_oe) |-> s_scl_low3)
        else $error("Data pull started outside the clock low phase.");
    a_ack_fall_low: assert property ($fell(o_sda_oe) |-> s_scl_low3)
        else $error("Data pull ended outside the clock low phase.");
    a_data_stands: assert property (i_scl && $past(i_scl) |-> $stable(o_sda_oe))
        else $error("Data moved while the bus clock was high.");
    a_idle_released: assert property (s_bus_idle |-> !o_sda_oe)
        else $error("Data pulled while the bus is idle.");
    a_levels_at_reset: assert property ($fell(i_rst) |-> {o_red_level, o_green_level, o_blue_level} == 24'hFF_FFFF)
        else $error("Levels not full after reset.");
    a_irq_quiet_reset: assert property ($fell(i_rst) |-> !o_irq_n_oe)
        else $error("Interrupt active after reset.");
    a_level_cause: assert property ($changed({o_red_level, o_green_level, o_blue_level}) |-> quiet_q <= 6'h0C)
        else $error("Level changed without a tick or bus access.");
endmodule
